/* File: src/pslm_pkg.sv */
package pslm_pkg;

  localparam int unsigned     PADDR_W         = 12;
  localparam logic [7:0]      IDX_CTRL0       = 8'h00;
  localparam logic [7:0]      IDX_IND         = 8'h1e;
  localparam logic [7:0]      IDX_STRAP       = 8'h20;
  localparam logic [7:0]      IDX_RXDATA      = 8'h21;
  localparam logic [7:0]      IDX_TXDATA      = 8'h22;

  localparam int unsigned     CTRL0_SPEED_BIT = 13;
  localparam int unsigned     IND_MODE_LSB    = 14;
  localparam int unsigned     STRAP_MODE_LSB  = 8;
  localparam int unsigned     STRAP_SPEED_BIT = 12;
  localparam int unsigned     STRAP_RMII_BIT  = 16;
  localparam int unsigned     TX_CNT_LSB      = 16;

  localparam logic [2:0]      MODE_MII        = 3'h0;
  localparam logic [2:0]      MODE_RMII       = 3'h1;
  localparam logic [2:0]      MODE_MII_PRE    = 3'h4;
  localparam logic [1:0]      IND_SPEED       = 2'h0;
  localparam logic [1:0]      IND_ACT         = 2'h1;
  localparam logic [1:0]      MGMT_ADDR_HI    = 2'h0;
  localparam logic [3:0]      RMII_LANES      = 4'h3;
  localparam logic [3:0]      MII_LANES       = 4'hf;

  localparam logic [1:0]      SETTLE_CYC      = 2'h3;
  localparam logic [1:0]      BUF_DEPTH       = 2'h2;
  localparam int unsigned     CLK_PERIOD_NS   = 25;
  localparam int unsigned     BLINK_HALF_NS   = 20000;
  localparam logic [9:0]      BLINK_CYC       = 10'(BLINK_HALF_NS / CLK_PERIOD_NS);

  typedef enum logic {
    PSLM_ST_HOLD,
    PSLM_ST_RUN
  } pslm_state_e;

endpackage

/* File: src/pslm_strap_phy.sv */
// How it works
// [R01] Strap levels are captured at start-up and become the configuration defaults.
// [R02] Strap pins are inputs during reset and start-up, then driven outputs.
// [R03] Management address low three bits come from three strap pins.
// [R04] Management address bits four and three always read zero.
// [R05] Interface mode is latched from three strap pins; 000 means MII.
// [R06] Mode 001 is RMII, 100 is MII with preamble restore, others reserved. The code runs mode 100 as plain MII.
// [R07] Speed strap level loads control register zero bit 13.
// [R08] Indicator register bits 15:14 choose the speed indicator behaviour.
// [R09] Mode 00 shows speed; mode 01 idles high and toggles on activity.
// [R10] Indicator modes 10 and 11 hold the output high, meaning off.
// [R11] MII receive drives four data bits, valid only with receive data valid.
// [R12] RMII receive delivers two bits each reference clock with CRS_DV.
// [R13] MII transmit takes four bits only while transmit enable is high.
// [R14] RMII transmit takes two bits each reference clock with TX_EN.
// [R15] Strap values are final at reset release and held until next reset.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module pslm_strap_phy
  import pslm_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [pslm_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          link_clk,
  input  wire logic                          tx_en,
  input  wire logic [3:0]                    txd,
  output logic                               rx_data3_out,
  output logic                               rx_dv,
  input  wire logic                          mgmt_addr_strap_bit0_in,
  output logic                               mgmt_addr_strap_bit0_out,
  output logic                               mgmt_addr_strap_bit0_oe,
  input  wire logic                          mgmt_addr_strap_bit1_in,
  output logic                               mgmt_addr_strap_bit1_out,
  output logic                               mgmt_addr_strap_bit1_oe,
  input  wire logic                          mgmt_addr_strap_bit2_in,
  output logic                               mgmt_addr_strap_bit2_out,
  output logic                               mgmt_addr_strap_bit2_oe,
  input  wire logic                          host_iface_mode_strap_bit0_in,
  output logic                               host_iface_mode_strap_bit0_out,
  output logic                               host_iface_mode_strap_bit0_oe,
  input  wire logic                          host_iface_mode_strap_bit1_in,
  output logic                               host_iface_mode_strap_bit1_out,
  output logic                               host_iface_mode_strap_bit1_oe,
  input  wire logic                          host_iface_mode_strap_bit2_in,
  output logic                               host_iface_mode_strap_bit2_out,
  output logic                               host_iface_mode_strap_bit2_oe,
  input  wire logic                          speed_indicator_out_in,
  output logic                               speed_indicator_out_out,
  output logic                               speed_indicator_out_oe
);
  import pslm_pkg::*;

  typedef struct packed {
    logic             lk_s1;
    logic             lk_s2;
    logic             lk_s3;
    logic [4:0]       tx_s1;
    logic [4:0]       tx_s2;
    logic [6:0]       st_s1;
    logic [6:0]       st_s2;
    pslm_state_e      state;
    logic [1:0]       settle;
    logic [2:0]       addr3;
    logic [2:0]       mode;
    logic             speed_strap;
    logic             speed100;
    logic [1:0]       ind_mode;
    logic [1:0][3:0]  mem;
    logic             wptr;
    logic             rptr;
    logic [1:0]       cnt;
    logic [3:0]       rxd;
    logic             rx_dv;
    logic [3:0]       tx_last;
    logic [15:0]      tx_cnt;
    logic [9:0]       blink_cnt;
    logic             blink;
    logic             act_seen;
    logic [6:0]       pin_out;
    logic [6:0]       pin_oe;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } pslm_regs_s;

  pslm_regs_s s_r;
  pslm_regs_s s_nxt;

  // Lane mask: RMII carries two bits per clock, MII four.
  function automatic logic [3:0] lane_mask(input logic [3:0] d, input logic rmii);
    lane_mask = d & (rmii ? RMII_LANES : MII_LANES);
  endfunction

  // Only the five registers answer; every other index is a slave error.
  function automatic logic reg_hit(input logic [7:0] i);
    unique case (i)
      IDX_CTRL0, IDX_IND, IDX_STRAP: begin
        reg_hit = 1'b1;
      end
      IDX_RXDATA, IDX_TXDATA: begin
        reg_hit = 1'b1;
      end
      default: begin
        reg_hit = 1'b0;
      end
    endcase
  endfunction

  function automatic logic [31:0] reg_read(input logic [7:0] idx, input pslm_regs_s s);
    logic [31:0] v;
    v = 32'h0;
    unique case (idx)
      IDX_CTRL0: begin
        v[CTRL0_SPEED_BIT] = s.speed100;
      end
      IDX_IND: begin
        v[IND_MODE_LSB +: 2] = s.ind_mode;
      end
      IDX_STRAP: begin
        // Address bits four and three are hard zero.
        v[4:0] = {MGMT_ADDR_HI, s.addr3};
        v[STRAP_MODE_LSB +: 3] = s.mode;
        v[STRAP_SPEED_BIT] = s.speed_strap;
        v[STRAP_RMII_BIT] = (s.mode == MODE_RMII);
      end
      IDX_RXDATA: begin
        v[1:0] = s.cnt;
      end
      IDX_TXDATA: begin
        v = {s.tx_cnt, 12'h0, s.tx_last};
      end
      default: begin
        v = 32'h0;
      end
    endcase
    reg_read = v;
  endfunction

  logic       lk_fall;
  logic       running;
  logic       rmii;
  logic       mode_ok;
  logic       mapped;
  logic [7:0] idx;
  logic       access;
  logic       done;
  logic       push;
  logic       pop;
  logic       tx_take;
  logic       activity;

  always_comb begin
    s_nxt = s_r;
    // Pins and the link clock come from outside, so two flops first.
    s_nxt.lk_s1 = link_clk;
    s_nxt.lk_s2 = s_r.lk_s1;
    s_nxt.lk_s3 = s_r.lk_s2;
    s_nxt.tx_s1 = {tx_en, txd};
    s_nxt.tx_s2 = s_r.tx_s1;
    // Strap order: address bits, then mode bits, then the speed pin.
    s_nxt.st_s1[0] = mgmt_addr_strap_bit0_in;
    s_nxt.st_s1[1] = mgmt_addr_strap_bit1_in;
    s_nxt.st_s1[2] = mgmt_addr_strap_bit2_in;
    s_nxt.st_s1[3] = host_iface_mode_strap_bit0_in;
    s_nxt.st_s1[4] = host_iface_mode_strap_bit1_in;
    s_nxt.st_s1[5] = host_iface_mode_strap_bit2_in;
    s_nxt.st_s1[6] = speed_indicator_out_in;
    s_nxt.st_s2 = s_r.st_s1;
    // Both directions act after the link falling edge: the partner launches
    // on the rising edge, so data is stable by then.
    lk_fall = s_r.lk_s3 & ~s_r.lk_s2;
    running = (s_r.state == PSLM_ST_RUN);
    rmii = (s_r.mode == MODE_RMII);
    // Mode check gates the data paths.
    // [R06] Reserved modes idle.
    unique case (s_r.mode)
      MODE_MII, MODE_RMII, MODE_MII_PRE: begin
        mode_ok = 1'b1;
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase

    unique case (s_r.state)
      PSLM_ST_HOLD: begin
        // [R02] Pins released during start-up.
        s_nxt.pin_oe = 7'h0;
        if (s_r.settle == SETTLE_CYC) begin
          // [R01] [R15] Capture straps once.
          s_nxt.state = PSLM_ST_RUN;
          // [R03] Address from straps.
          s_nxt.addr3 = s_r.st_s2[2:0];
          // [R05] Interface mode latch.
          s_nxt.mode = s_r.st_s2[5:3];
          s_nxt.speed_strap = s_r.st_s2[6];
          // [R07] Speed default load.
          s_nxt.speed100 = s_r.st_s2[6];
        end else begin
          s_nxt.settle = s_r.settle + 2'h1;
        end
      end
      PSLM_ST_RUN: begin
        // [R02] Normal output function.
        s_nxt.pin_oe = 7'h7f;
      end
    endcase

    // Register bus: pready comes from a flop, so each access has one wait, except a receive data write to a full buffer, which waits until a unit drains.
    idx = paddr[9:2];
    mapped = (paddr[PADDR_W-1:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
             reg_hit(idx);
    access = psel & penable & ~s_r.pready;
    done = psel & penable & s_r.pready;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (access && !(pwrite && mapped && idx == IDX_RXDATA && s_r.cnt == BUF_DEPTH)) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~mapped;
      s_nxt.prdata = (mapped && !pwrite) ? reg_read(idx, s_r) : 32'h0;
    end
    push = 1'b0;
    if (done && pwrite && mapped) begin
      unique case (idx)
        IDX_CTRL0: begin
          s_nxt.speed100 = pwdata[CTRL0_SPEED_BIT];
        end
        IDX_IND: begin
          // [R08] Indicator mode field.
          s_nxt.ind_mode = pwdata[IND_MODE_LSB +: 2];
        end
        IDX_RXDATA: begin
          push = 1'b1;
        end
        default: begin
          push = 1'b0;
        end
      endcase
    end

    // Receive path drains the two-entry buffer one unit per link clock.
    pop = 1'b0;
    tx_take = 1'b0;
    if (lk_fall && running && mode_ok) begin
      if (s_r.cnt != 2'h0) begin
        pop = 1'b1;
        // [R11] [R12] Data valid only with rx_dv.
        s_nxt.rxd = lane_mask(s_r.mem[s_r.rptr], rmii);
        s_nxt.rx_dv = 1'b1;
      end else begin
        s_nxt.rxd = 4'h0;
        s_nxt.rx_dv = 1'b0;
      end
      // [R13] [R14] Transmit taken with enable.
      if (s_r.tx_s2[4]) begin
        tx_take = 1'b1;
        s_nxt.tx_last = lane_mask(s_r.tx_s2[3:0], rmii);
        s_nxt.tx_cnt = s_r.tx_cnt + 16'h1;
      end
    end else if (!running || !mode_ok) begin
      s_nxt.rxd = 4'h0;
      s_nxt.rx_dv = 1'b0;
    end
    // Pointers toggle; the level counter tells a full buffer from an empty one.
    if (push) begin
      s_nxt.mem[s_r.wptr] = pwdata[3:0];
      s_nxt.wptr = ~s_r.wptr;
    end
    if (pop) begin
      s_nxt.rptr = ~s_r.rptr;
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};

    // Activity is gathered over a blink half-period so short bursts show.
    activity = pop | tx_take;
    s_nxt.act_seen = s_r.act_seen | activity;
    if (s_r.blink_cnt == BLINK_CYC - 10'h1) begin
      s_nxt.blink_cnt = 10'h0;
      s_nxt.blink = s_r.act_seen ? ~s_r.blink : 1'b1;
      s_nxt.act_seen = activity;
    end else begin
      s_nxt.blink_cnt = s_r.blink_cnt + 10'h1;
    end

    // Normal pin functions: receive data bits, collision, carrier, error.
    s_nxt.pin_out[2:0] = s_nxt.rxd[2:0];
    s_nxt.pin_out[3] = 1'b0;
    s_nxt.pin_out[4] = s_nxt.rx_dv;
    s_nxt.pin_out[5] = 1'b0;
    unique case (s_r.ind_mode)
      // [R09] Speed view: high means 10.
      IND_SPEED: begin
        s_nxt.pin_out[6] = ~s_r.speed100;
      end
      // [R09] Activity view toggles.
      IND_ACT: begin
        s_nxt.pin_out[6] = s_r.blink;
      end
      // [R10] Reserved modes stay off.
      default: begin
        s_nxt.pin_out[6] = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.state <= PSLM_ST_HOLD;
      s_r.blink <= 1'b1;
      s_r.pin_out <= 7'h0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata                          = s_r.prdata;
  assign pready                          = s_r.pready;
  assign pslverr                         = s_r.pslverr;
  assign rx_data3_out                    = s_r.rxd[3];
  assign rx_dv                           = s_r.rx_dv;
  assign mgmt_addr_strap_bit0_out        = s_r.pin_out[0];
  assign mgmt_addr_strap_bit0_oe         = s_r.pin_oe[0];
  assign mgmt_addr_strap_bit1_out        = s_r.pin_out[1];
  assign mgmt_addr_strap_bit1_oe         = s_r.pin_oe[1];
  assign mgmt_addr_strap_bit2_out        = s_r.pin_out[2];
  assign mgmt_addr_strap_bit2_oe         = s_r.pin_oe[2];
  assign host_iface_mode_strap_bit0_out  = s_r.pin_out[3];
  assign host_iface_mode_strap_bit0_oe   = s_r.pin_oe[3];
  assign host_iface_mode_strap_bit1_out  = s_r.pin_out[4];
  assign host_iface_mode_strap_bit1_oe   = s_r.pin_oe[4];
  assign host_iface_mode_strap_bit2_out  = s_r.pin_out[5];
  assign host_iface_mode_strap_bit2_oe   = s_r.pin_oe[5];
  assign speed_indicator_out_out         = s_r.pin_out[6];
  assign speed_indicator_out_oe          = s_r.pin_oe[6];

endmodule

/* File: verif/pslm_mac_model.sv */
`timescale 1ns/10ps
module pslm_mac_model (
  input  wire logic       run,
  input  wire logic       en,
  input  wire logic [3:0] nib,
  output logic            link_clk,
  output logic            tx_en,
  output logic [3:0]      txd
);
  // The clock stands still low while run is low.
  initial begin
    link_clk = 1'b0;
    tx_en = 1'b0;
    txd = 4'h0;
    #37;
    forever #100 if (run || link_clk) link_clk = ~link_clk;
  end
  // Launch after rise.
  // An idle bus shows the inverse of its last value, so stale data cannot pass for a unit.
  always @(posedge link_clk) begin
    tx_en <= en;
    txd <= en ? nib : ~txd;
  end
endmodule

/* File: verif/pslm_strap_phy_bench.sv */
`timescale 1ns/10ps
module pslm_strap_phy_bench;
  import pslm_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0, men = 0;
  logic [PADDR_W-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rx_data3_out, rx_dv, link_clk, tx_en;
  logic [3:0] txd, mnib = 4'h0;
  logic lo;
  logic [6:0] ext = 7'h41;
  logic mgmt_addr_strap_bit0_out, mgmt_addr_strap_bit0_oe;
  logic mgmt_addr_strap_bit1_out, mgmt_addr_strap_bit1_oe;
  logic mgmt_addr_strap_bit2_out, mgmt_addr_strap_bit2_oe;
  logic host_iface_mode_strap_bit0_out, host_iface_mode_strap_bit0_oe;
  logic host_iface_mode_strap_bit1_out, host_iface_mode_strap_bit1_oe;
  logic host_iface_mode_strap_bit2_out, host_iface_mode_strap_bit2_oe;
  logic speed_indicator_out_out, speed_indicator_out_oe;
  // Each pad shows the block while it drives, else the board strap or pull.
  wire mgmt_addr_strap_bit0_in = mgmt_addr_strap_bit0_oe ? mgmt_addr_strap_bit0_out : ext[0];
  wire mgmt_addr_strap_bit1_in = mgmt_addr_strap_bit1_oe ? mgmt_addr_strap_bit1_out : ext[1];
  wire mgmt_addr_strap_bit2_in = mgmt_addr_strap_bit2_oe ? mgmt_addr_strap_bit2_out : ext[2];
  wire host_iface_mode_strap_bit0_in =
    host_iface_mode_strap_bit0_oe ? host_iface_mode_strap_bit0_out : ext[3];
  wire host_iface_mode_strap_bit1_in =
    host_iface_mode_strap_bit1_oe ? host_iface_mode_strap_bit1_out : ext[4];
  wire host_iface_mode_strap_bit2_in =
    host_iface_mode_strap_bit2_oe ? host_iface_mode_strap_bit2_out : ext[5];
  wire speed_indicator_out_in = speed_indicator_out_oe ? speed_indicator_out_out : ext[6];
  wire [3:0] rxnib = {rx_data3_out, mgmt_addr_strap_bit2_out, mgmt_addr_strap_bit1_out,
    mgmt_addr_strap_bit0_out};
  int n_fail = 0, comparisons = 0, cyc = 0;
  pslm_strap_phy dut_u (.*);
  pslm_mac_model mac_u (.run, .en(men), .nib(mnib), .link_clk, .tx_en, .txd);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic rst(input logic [6:0] v);
    ext <= v;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  task automatic send(input logic e, input logic [3:0] n);
    @(posedge link_clk);
    @(posedge pclk);
    men <= e;
    mnib <= n;
  endtask
  task automatic wait_dv();
    int n = 0;
    while (rx_dv !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask
  initial begin
    @(posedge pclk);
    rst(7'h4d);
    apb(0, 12'h080, 0);
    chk(rd, 32'h0001_1105);
    apb(1, 12'h080, 0);
    apb(0, 12'h080, 0);
    chk(rd, 32'h0001_1105);
    apb(0, 12'h000, 0);
    chk(rd & 32'h0000_2000, 32'h0000_2000);
    apb(0, 12'h0fc, 0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1, 12'h084, 32'hf);
    run <= 1'b1;
    wait_dv();
    chk({28'h0, rxnib}, 32'h3);
    send(1, 4'he);
    send(0, 4'h1);
    repeat (24) @(posedge pclk);
    run <= 1'b0;
    apb(0, 12'h088, 0);
    chk(rd, 32'h0001_0002);
    rst(7'h41);
    apb(0, 12'h080, 0);
    chk(rd, 32'h0000_1001);
    chk({31'h0, speed_indicator_out_out}, 32'h0);
    for (int m = 1; m < 4; m++) begin
      apb(1, 12'h078, 32'(m) << 14);
      chk({31'h0, speed_indicator_out_out}, 32'h1);
    end
    apb(1, 12'h078, 0);
    apb(1, 12'h000, 0);
    chk({31'h0, speed_indicator_out_out}, 32'h1);
    apb(1, 12'h084, 32'h9);
    apb(1, 12'h084, 32'h6);
    apb(0, 12'h084, 0);
    chk(rd & 32'h3, 32'h2);
    run <= 1'b1;
    wait_dv();
    chk({28'h0, rxnib}, 32'h9);
    repeat (8) @(posedge pclk);
    chk({28'h0, rxnib}, 32'h6);
    send(1, 4'ha);
    send(1, 4'h5);
    send(1, 4'hc);
    send(0, 4'hf);
    repeat (40) @(posedge pclk);
    run <= 1'b0;
    apb(0, 12'h088, 0);
    chk(rd, 32'h0003_000c);
    apb(1, 12'h078, 32'h0000_4000);
    run <= 1'b1;
    men <= 1'b1;
    lo = 1'b0;
    repeat (1700) begin
      @(posedge pclk);
      lo |= ~speed_indicator_out_out;
    end
    chk({31'h0, lo}, 32'h1);
    complete_run();
  end
endmodule

/* File: verif/pslm_strap_phy_monitor.sv */
`timescale 1ns/10ps
module pslm_strap_phy_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_dv,
  input wire logic rx_data3_out,
  input wire logic mgmt_addr_strap_bit0_oe,
  input wire logic host_iface_mode_strap_bit0_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OE_START: assert property ($rose(presetn) |-> !mgmt_addr_strap_bit0_oe [*3])
    else $error("Strap pin driven during start-up.");
  AST_OE_ON: assert property ($rose(presetn) |-> ##[1:6] mgmt_addr_strap_bit0_oe)
    else $error("Strap pin not driven after start-up.");
  AST_OE_STAY: assert property (mgmt_addr_strap_bit0_oe |=> mgmt_addr_strap_bit0_oe)
    else $error("Strap pin released before reset.");
  AST_OE_SAME: assert property (mgmt_addr_strap_bit0_oe == host_iface_mode_strap_bit0_oe)
    else $error("Strap pins disagree on drive.");
  AST_READ_ANSWER: assert property (psel && penable && !pready && !pwrite |=> pready)
    else $error("Read not answered in one cycle.");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle.");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("Error without ready.");
  AST_RXDV_HOLD: assert property ($rose(rx_dv) |=> rx_dv [*6])
    else $error("Receive valid shorter than a link period.");
  AST_RXD_STABLE: assert property ($rose(rx_dv) |=> $stable(rx_data3_out) [*6])
    else $error("Receive data moved inside a unit.");
  COV_ERR: cover property (pslverr);
  COV_RX: cover property ($rose(rx_dv));
  COV_OE: cover property ($rose(mgmt_addr_strap_bit0_oe));
endmodule
bind pslm_strap_phy pslm_strap_phy_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .rx_dv, .rx_data3_out, .mgmt_addr_strap_bit0_oe,
  .host_iface_mode_strap_bit0_oe);
